// ### logic/ccdb_params.svh
// Function
// R1 - Compare writes hit preload, move on update
// R2 - Active value compared with counter, match output
// R3 - Input mode holds counter caught at capture
// R4 - Burst length n gives n+1 transfers
// R5 - Port access is burst transfer, not storage
// R6 - Base offset counts words from control one
// R7 - Target is control one plus (base+index)*4
// R8 - Index advances per port access, zero to length
// R9 - Software writes reserved control bits as zero
// R10 - Software sets DMA, burst, update request, enable
// R11 - Each update request runs full burst from base; a request during a running burst merges into it, no new burst; code starts a new one at the last access
// R12 - Direction zero means output, else input
// R13 - Channel enable clear blocks capture
// R14 - Request held until burst done, index cleared
`ifndef CCDB_PARAMS_SVH
`define CCDB_PARAMS_SVH
// Byte offsets of the register words
`define CCDB_OFF_CTRL_ONE 8'h00
`define CCDB_OFF_CH2 8'h38
`define CCDB_OFF_CH3 8'h3C
`define CCDB_OFF_CH4 8'h40
`define CCDB_OFF_BCTL 8'h48
`define CCDB_OFF_PORT 8'h4C
`define CCDB_OFF_CFG 8'h50
`define CCDB_OFF_STAT 8'h54
// Field positions
`define CCDB_BBASE_LSB 0
`define CCDB_BLEN_LSB 8
`define CCDB_CFG_PE_LSB 0
`define CCDB_CFG_EN_LSB 4
`define CCDB_CFG_DIR_LSB 8
`define CCDB_CFG_URQ_BIT 16
`define CCDB_STAT_ACT_BIT 8
`define CCDB_STAT_CMP_LSB 9
// Reset values and codes
`define CCDB_CMP_RST 16'h0000
`define CCDB_FIELD_RST 5'h00
`define CCDB_DIR_OUTPUT 2'h0
`define CCDB_RESP_OKAY 2'h0
`define CCDB_RESP_SLVERR 2'h2
`endif

// ### logic/ccdb_pkg.sv
package ccdb_pkg;
    // Register word selected by an address
    typedef enum logic [2:0] {
        SEL_NONE, SEL_CH2, SEL_CH3, SEL_CH4,
        SEL_BCTL, SEL_PORT, SEL_CFG, SEL_STAT
    } ccdb_sel_t;
endpackage : ccdb_pkg

// ### logic/ccdb_fifo.sv
`timescale 1ns/1ps
module ccdb_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // Storage, DEPTH is a power of two
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg != FULL;
    assign push = in_valid && in_ready;
    // Refill output register when it is empty or being taken
    assign pop = (count_reg != '0) && (!out_valid || out_ready);

    // Array write, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered read side
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem[rd_ptr_reg];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : ccdb_fifo

// ### logic/ccdb_chan.sv
`timescale 1ns/1ps
`include "ccdb_params.svh"
module ccdb_chan (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic update_evt,
    input wire logic capture_evt,
    input wire logic [1:0] dir_sel,
    input wire logic chan_en,
    input wire logic preload_en,
    input wire logic [15:0] counter,
    output logic [15:0] value,
    output logic compare_out
);
    logic [15:0] preload_reg; // Software view, also capture holder
    logic [15:0] active_reg; // Value the comparator uses
    logic is_out;
    logic cap_ok;

    assign is_out = dir_sel == `CCDB_DIR_OUTPUT; // R12
    assign cap_ok = !is_out && chan_en && capture_evt; // R13
    assign value = preload_reg;

    // Capture beats a same-cycle write so no event is lost
    always_ff @(posedge clk) begin
        if (rst) preload_reg <= `CCDB_CMP_RST;
        else if (cap_ok) preload_reg <= counter; // R3
        else if (wr_en) preload_reg <= wr_data; // R1
    end

    // Active copy: direct load or update transfer
    always_ff @(posedge clk) begin
        if (rst) active_reg <= `CCDB_CMP_RST;
        else if (is_out && wr_en && !preload_en) active_reg <= wr_data; // R1
        else if (is_out && update_evt && preload_en) active_reg <= preload_reg; // R1
    end

    // Match flag, forced low while channel is off
    always_ff @(posedge clk) begin
        if (rst) compare_out <= 1'b0;
        else compare_out <= is_out && chan_en && (counter == active_reg); // R2
    end

    property p_direct_load;
        @(posedge clk) disable iff (rst)
        is_out && wr_en && !preload_en && !update_evt |=> active_reg == $past(wr_data);
    endproperty
    a_direct_load: assert property (p_direct_load) else $error("direct load missed"); // R1
    property p_update_copy;
        @(posedge clk) disable iff (rst)
        is_out && preload_en && update_evt |=> active_reg == $past(preload_reg);
    endproperty
    a_update_copy: assert property (p_update_copy) else $error("update copy missed"); // R1
    property p_capture;
        @(posedge clk) disable iff (rst)
        cap_ok |=> value == $past(counter);
    endproperty
    a_capture: assert property (p_capture) else $error("capture not latched"); // R3
    property p_no_capture;
        @(posedge clk) disable iff (rst)
        capture_evt && (is_out || !chan_en) && !wr_en |=> $stable(value);
    endproperty
    a_no_capture: assert property (p_no_capture) else $error("blocked capture stored"); // R13
    property p_match;
        @(posedge clk) disable iff (rst)
        is_out && chan_en && counter == active_reg |=> compare_out;
    endproperty
    a_match: assert property (p_match) else $error("match not signalled"); // R2
    c_capture: cover property (@(posedge clk) disable iff (rst) cap_ok);
endmodule : ccdb_chan

// ### logic/ccdb_top.sv
`timescale 1ns/1ps
`include "ccdb_params.svh"
module ccdb_top #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    // Register bus, AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Timer side, same clock
    input wire logic [15:0] COUNTER_VALUE,
    input wire logic UPDATE_EVT,
    input wire logic [2:0] CAPTURE_EVT,
    output logic [2:0] COMPARE_OUT,
    output logic DMA_REQ
);
    ////////////////////////////////////////////////////////////////////
    // Decode helpers
    // Byte address to register word, misaligned is unmapped
    function automatic ccdb_pkg::ccdb_sel_t decode(input logic [7:0] a);
        case (a)
            `CCDB_OFF_CH2: decode = ccdb_pkg::SEL_CH2;
            `CCDB_OFF_CH3: decode = ccdb_pkg::SEL_CH3;
            `CCDB_OFF_CH4: decode = ccdb_pkg::SEL_CH4;
            `CCDB_OFF_BCTL: decode = ccdb_pkg::SEL_BCTL;
            `CCDB_OFF_PORT: decode = ccdb_pkg::SEL_PORT;
            `CCDB_OFF_CFG: decode = ccdb_pkg::SEL_CFG;
            `CCDB_OFF_STAT: decode = ccdb_pkg::SEL_STAT;
            default: decode = ccdb_pkg::SEL_NONE;
        endcase
    endfunction : decode

    // Byte-lane merge of new write data into old word
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0] strb);
        merge = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) merge[b*8 +: 8] = new_w[b*8 +: 8];
        end
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // State
    logic [4:0] blen_reg; // Burst length field
    logic [4:0] bbase_reg; // Burst base word offset
    logic [2:0] pe_reg; // Preload enables, channels 2..4
    logic [2:0] en_reg; // Channel enables
    logic [5:0] dir_reg; // Direction selectors, two bits each
    logic urq_reg; // Update request enable
    logic [4:0] idx_reg; // Running transfer index
    logic active_reg; // Burst in progress
    logic [5:0] acc_cnt_reg; // Accesses in current burst, for checks
    // Write channel holding registers
    logic aw_have_reg, w_have_reg, bvalid_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg;
    // Read channel
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    // Channel wiring
    logic [2:0][15:0] ch_val;
    logic [2:0] ch_wr;
    logic [2:0][15:0] ch_wdata;
    // Burst FIFO: {channel index, half-word}
    logic fifo_in_ready, fifo_push, fifo_out_valid, fifo_out_ready;
    logic [17:0] fifo_out_data;
    // Decoded selections
    ccdb_pkg::ccdb_sel_t wsel, rsel, tsel, wdst, rdst;
    logic [5:0] tgt_word; // Target word index
    logic [1:0] t_ch; // Target channel number
    // Handshake and burst strobes
    logic t_is_ch, wr_pend, wr_blocked, wr_fire, rd_fire;
    logic port_access, last_access, start, active_next;
    // Assembled register words
    logic [31:0] bctl_word, cfg_word, stat_word, wr_old, wr_val, rd_val;

    ////////////////////////////////////////////////////////////////////
    // Burst target and readback
    // Word index from control one; the port never points at itself
    assign tgt_word = {1'b0, bbase_reg} + {1'b0, idx_reg}; // R6
    always_comb begin
        tsel = decode({tgt_word, 2'b00}); // R7
        if (tsel == ccdb_pkg::SEL_PORT) tsel = ccdb_pkg::SEL_NONE;
    end
    assign t_is_ch = tsel inside {ccdb_pkg::SEL_CH2, ccdb_pkg::SEL_CH3,
                                  ccdb_pkg::SEL_CH4};
    assign t_ch = (tsel == ccdb_pkg::SEL_CH2) ? 2'h0 :
                  (tsel == ccdb_pkg::SEL_CH3) ? 2'h1 : 2'h2;

    // Reserved fields read as zero
    assign bctl_word = {19'h00000, blen_reg, 3'h0, bbase_reg};
    assign cfg_word = {15'h0000, urq_reg, 2'h0, dir_reg, 1'b0, en_reg, 1'b0, pe_reg};
    assign stat_word = {20'h00000, COMPARE_OUT, active_reg, 3'h0, idx_reg};

    // Port accesses land on the computed target
    assign wdst = (wsel == ccdb_pkg::SEL_PORT) ? tsel : wsel; // R5
    assign rdst = (rsel == ccdb_pkg::SEL_PORT) ? tsel : rsel; // R5

    // Readback mux, reused for merge and reads
    function automatic logic [31:0] rd_word(input ccdb_pkg::ccdb_sel_t s,
                                            input logic [2:0][15:0] v,
                                            input logic [31:0] bc,
                                            input logic [31:0] cf,
                                            input logic [31:0] st);
        case (s)
            ccdb_pkg::SEL_CH2: rd_word = {16'h0000, v[0]};
            ccdb_pkg::SEL_CH3: rd_word = {16'h0000, v[1]};
            ccdb_pkg::SEL_CH4: rd_word = {16'h0000, v[2]};
            ccdb_pkg::SEL_BCTL: rd_word = bc;
            ccdb_pkg::SEL_CFG: rd_word = cf;
            ccdb_pkg::SEL_STAT: rd_word = st;
            default: rd_word = 32'h00000000;
        endcase
    endfunction : rd_word

    assign wr_old = rd_word(wdst, ch_val, bctl_word, cfg_word, stat_word);
    assign wr_val = merge(wr_old, wdata_reg, wstrb_reg);
    assign rd_val = rd_word(rdst, ch_val, bctl_word, cfg_word, stat_word);

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path
    assign wsel = decode(awaddr_reg);
    assign S_AXI_AWREADY = !aw_have_reg && !bvalid_reg;
    assign S_AXI_WREADY = !w_have_reg && !bvalid_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign wr_pend = aw_have_reg && w_have_reg && !bvalid_reg;
    // A full FIFO stalls a port write until a slot frees
    assign wr_blocked = (wsel == ccdb_pkg::SEL_PORT) && t_is_ch && !fifo_in_ready;
    assign wr_fire = wr_pend && !wr_blocked;

    // Address and data may arrive in either order
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            aw_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            w_have_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    // Write response, error for unmapped words
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `CCDB_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wsel == ccdb_pkg::SEL_NONE) ? `CCDB_RESP_SLVERR : `CCDB_RESP_OKAY;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path
    // Reads wait while a write executes, so the index moves once a cycle
    assign S_AXI_ARREADY = !rvalid_reg && !wr_pend;
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rsel = decode(S_AXI_ARADDR);
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

    // Data sampled at address acceptance
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `CCDB_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= (rsel == ccdb_pkg::SEL_NONE) ? `CCDB_RESP_SLVERR : `CCDB_RESP_OKAY;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers
    // Only the documented fields are stored
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            blen_reg <= `CCDB_FIELD_RST;
            bbase_reg <= `CCDB_FIELD_RST;
        end else if (wr_fire && wdst == ccdb_pkg::SEL_BCTL) begin
            blen_reg <= wr_val[`CCDB_BLEN_LSB +: 5]; // R4
            bbase_reg <= wr_val[`CCDB_BBASE_LSB +: 5]; // R6
        end
    end

    // Channel configuration word
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pe_reg <= 3'h0;
            en_reg <= 3'h0;
            dir_reg <= 6'h00;
            urq_reg <= 1'b0;
        end else if (wr_fire && wdst == ccdb_pkg::SEL_CFG) begin
            pe_reg <= wr_val[`CCDB_CFG_PE_LSB +: 3];
            en_reg <= wr_val[`CCDB_CFG_EN_LSB +: 3];
            dir_reg <= wr_val[`CCDB_CFG_DIR_LSB +: 6];
            urq_reg <= wr_val[`CCDB_CFG_URQ_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Burst sequencing
    assign port_access = (wr_fire && wsel == ccdb_pkg::SEL_PORT) ||
                         (rd_fire && rsel == ccdb_pkg::SEL_PORT); // R5
    assign last_access = port_access && (idx_reg == blen_reg); // R4
    assign start = UPDATE_EVT && urq_reg;
    // A new request merges with a running burst; one at its last access starts a new burst from base
    assign active_next = (active_reg && !last_access) || start; // R14
    assign DMA_REQ = active_reg;

    // Index walks 0..length then returns to zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) idx_reg <= `CCDB_FIELD_RST;
        else if (last_access) idx_reg <= `CCDB_FIELD_RST; // R14
        else if (port_access) idx_reg <= idx_reg + 5'h01; // R8
    end

    // Request level
    always_ff @(posedge CLK) begin
        if (SYS_RST) active_reg <= 1'b0;
        else active_reg <= active_next; // R11
    end

    // Access count, read only by checks
    always_ff @(posedge CLK) begin
        if (SYS_RST) acc_cnt_reg <= 6'h00;
        else if (!active_reg && active_next) acc_cnt_reg <= 6'h00;
        else if (port_access && active_reg) acc_cnt_reg <= acc_cnt_reg + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////
    // Burst FIFO and channels
    // Only channel targets are buffered; control targets are written directly
    assign fifo_push = wr_fire && wsel == ccdb_pkg::SEL_PORT && t_is_ch;
    // Drain stalls while a direct channel write owns the write port
    assign fifo_out_ready = !(wr_fire && wsel inside {ccdb_pkg::SEL_CH2,
                              ccdb_pkg::SEL_CH3, ccdb_pkg::SEL_CH4});

    ccdb_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .rst(SYS_RST),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({t_ch, wr_val[15:0]}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // One instance per channel 2..4
    for (genvar i = 0; i < 3; i++) begin : g_ch
        localparam ccdb_pkg::ccdb_sel_t MY_SEL = ccdb_pkg::ccdb_sel_t'(i + 1);
        logic direct;
        logic drained;
        assign direct = wr_fire && wsel == MY_SEL;
        assign drained = fifo_out_valid && fifo_out_ready &&
                         fifo_out_data[17:16] == 2'(i);
        assign ch_wr[i] = direct || drained;
        assign ch_wdata[i] = direct ? wr_val[15:0] : fifo_out_data[15:0];
        ccdb_chan u_chan (
            .clk(CLK),
            .rst(SYS_RST),
            .wr_en(ch_wr[i]),
            .wr_data(ch_wdata[i]),
            .update_evt(UPDATE_EVT),
            .capture_evt(CAPTURE_EVT[i]),
            .dir_sel(dir_reg[2*i +: 2]),
            .chan_en(en_reg[i]),
            .preload_en(pe_reg[i]),
            .counter(COUNTER_VALUE),
            .value(ch_val[i]),
            .compare_out(COMPARE_OUT[i])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_idx_step;
        @(posedge CLK) disable iff (SYS_RST)
        port_access && !last_access |=> idx_reg == $past(idx_reg) + 5'h01;
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("index did not advance"); // R8
    property p_idx_wrap;
        @(posedge CLK) disable iff (SYS_RST)
        last_access |=> idx_reg == 5'h00;
    endproperty
    a_idx_wrap: assert property (p_idx_wrap) else $error("index not cleared"); // R14
    property p_len;
        @(posedge CLK) disable iff (SYS_RST)
        $fell(active_reg) |-> acc_cnt_reg == {1'b0, $past(blen_reg)} + 6'h01;
    endproperty
    a_len: assert property (p_len) else $error("burst length wrong"); // R4
    property p_start;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(DMA_REQ) |-> idx_reg == 5'h00;
    endproperty
    a_start: assert property (p_start) else $error("burst not from base"); // R11
    property p_hold;
        @(posedge CLK) disable iff (SYS_RST)
        DMA_REQ && !last_access |=> DMA_REQ;
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped early"); // R14
    property p_port_no_store;
        @(posedge CLK) disable iff (SYS_RST)
        wr_fire && wsel == ccdb_pkg::SEL_PORT && tsel != ccdb_pkg::SEL_BCTL |=>
            $stable(blen_reg) && $stable(bbase_reg);
    endproperty
    a_port_no_store: assert property (p_port_no_store) else $error("port stored"); // R5
    property p_redirect;
        @(posedge CLK) disable iff (SYS_RST)
        bbase_reg == 5'h0E && idx_reg == 5'h01 |-> tsel == ccdb_pkg::SEL_CH3;
    endproperty
    a_redirect: assert property (p_redirect) else $error("target address wrong"); // R7
    property p_base;
        @(posedge CLK) disable iff (SYS_RST)
        bbase_reg == 5'h12 && idx_reg == 5'h00 |-> tsel == ccdb_pkg::SEL_BCTL;
    endproperty
    a_base: assert property (p_base) else $error("base offset wrong"); // R6
    c_burst_done: cover property (@(posedge CLK) disable iff (SYS_RST) $fell(DMA_REQ));
    c_fifo_full: cover property (@(posedge CLK) disable iff (SYS_RST) !fifo_in_ready);
    c_long_burst: cover property (@(posedge CLK) disable iff (SYS_RST)
        last_access && blen_reg == 5'h11);
endmodule : ccdb_top

// ### tb/ccdb_dma.sv
`timescale 1ns/1ps
// DMA controller stand-in; also carries the bench's register writes
module ccdb_dma (
    input wire logic clk,
    input wire logic dma_req,
    output logic [7:0] aw,
    output logic awv,
    input wire logic awr,
    output logic [31:0] wd,
    output logic wv,
    input wire logic wrdy,
    input wire logic bv,
    output logic br
);
    logic [15:0] items[$]; // Memory buffer, one half-word per transfer
    int slow = 0; // Idle cycles before a transfer, to stall
    initial begin
        {aw, awv, wd, wv, br} = '0;
    end
    ////////////////////////////////////////
    // One write; each channel released only when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        forever begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
    endtask : wr
    // Serve a request only while buffer items remain, as a non-circular channel
    initial forever begin
        @(posedge clk);
        if (dma_req && items.size() != 0) begin
            repeat (slow) @(posedge clk);
            wr(8'h4C, {16'h0000, items.pop_front()});
        end
    end
endmodule : ccdb_dma

// ### tb/ccdb_top_test.sv
`timescale 1ns/1ps
module ccdb_top_test;
    logic clk = 1'b0; // 50 MHz bus clock
    logic rst = 1'b1; // Held for four cycles
    logic [7:0] aw, ar = 8'h00;
    logic awv, awr, wv, wrdy, bv, br, arr, rv, arv = 1'b0, rr = 1'b0, upd = 1'b0, req;
    logic [31:0] wd, rdata, d;
    logic [1:0] bresp, rresp, lresp;
    logic [15:0] cnt = 16'h0000; // Timer counter
    logic [2:0] cap = 3'h0, cmp;
    int err_count = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    ccdb_top #(.FIFO_DEPTH(16)) ccdb_top_i (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(aw),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
        .COUNTER_VALUE(cnt), .UPDATE_EVT(upd), .CAPTURE_EVT(cap), .COMPARE_OUT(cmp),
        .DMA_REQ(req));
    ccdb_dma ccdb_dma_i (.clk(clk), .dma_req(req), .aw(aw), .awv(awv), .awr(awr), .wd(wd),
        .wv(wv), .wrdy(wrdy), .bv(bv), .br(br));
    ////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : check
    // Read; data and response taken at the edge that sees RVALID
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ar <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        forever begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rdata;
        lresp = rresp;
        rr <= 1'b0;
    endtask : rd
    task automatic ev(input logic u, input logic [2:0] c);
        @(posedge clk);
        upd <= u;
        cap <= c;
        @(posedge clk);
        upd <= 1'b0;
        cap <= 3'h0;
        #1;
    endtask : ev
    // Compare output lags the counter by one registered cycle
    task automatic setc(input logic [15:0] v);
        @(posedge clk);
        cnt <= v;
        repeat (2) @(posedge clk);
        #1;
    endtask : setc
    ////////////////////////////////////////
    task automatic t_reset;
        rd(8'h48);
        check("burst ctl reset", d, 32'h0000_0000);
        rd(8'h60);
        check("unmapped resp", {30'h0, lresp}, 32'h0000_0002);
        ccdb_dma_i.wr(8'h60, 32'h0000_0001);
        check("unmapped wresp", {30'h0, bresp}, 32'h0000_0002);
    endtask : t_reset
    task automatic t_compare;
        ccdb_dma_i.wr(8'h50, 32'h0000_0010);
        ccdb_dma_i.wr(8'h38, 32'h0000_1234);
        rd(8'h38);
        check("ch2 value", d, 32'h0000_1234);
        setc(16'h1234);
        check("ch2 match", {31'h0, cmp[0]}, 32'h1);
        ccdb_dma_i.wr(8'h50, 32'h0000_0011);
        ccdb_dma_i.wr(8'h38, 32'h0000_0050);
        setc(16'h1234);
        check("preload held", {31'h0, cmp[0]}, 32'h1);
        ev(1'b1, 3'h0);
        setc(16'h1234);
        check("preload moved", {31'h0, cmp[0]}, 32'h0);
    endtask : t_compare
    // Three transfers from word 0xE, twice; second round with a slow DMA
    task automatic t_burst;
        int n;
        ccdb_dma_i.items = '{16'h0A01, 16'h0A02, 16'h0A03, 16'h0B01, 16'h0B02, 16'h0B03};
        ccdb_dma_i.wr(8'h48, 32'h0000_020E);
        ccdb_dma_i.wr(8'h50, 32'h0001_0000);
        for (int k = 0; k < 2; k++) begin
            ccdb_dma_i.slow = k * 3;
            ev(1'b1, 3'h0);
            check("request up", {31'h0, req}, 32'h1);
            n = 0;
            while (req !== 1'b0 && n < 300) begin
                @(posedge clk);
                n++;
            end
            check("request down", {31'h0, req}, 32'h0);
            rd(8'h54);
            check("index cleared", {23'h0, d[8:0]}, 32'h0);
            for (int j = 0; j < 3; j++) begin
                rd(8'h38 + 8'(4 * j));
                check("target", d, {16'h0, 8'(8'h0A + k), 8'(j + 1)});
            end
        end
    endtask : t_burst
    task automatic t_capture;
        ccdb_dma_i.wr(8'h50, 32'h0000_0400);
        ccdb_dma_i.wr(8'h50, 32'h0000_0420);
        cnt <= 16'h0ABC;
        ev(1'b0, 3'h2);
        rd(8'h3C);
        check("capture", d, 32'h0000_0ABC);
        ccdb_dma_i.wr(8'h50, 32'h0000_0400);
        cnt <= 16'h0DEF;
        ev(1'b0, 3'h2);
        rd(8'h3C);
        check("capture gated", d, 32'h0000_0ABC);
    endtask : t_capture
    task automatic results;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_compare;
        t_burst;
        t_capture;
        results;
    end
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        err_count++;
        results;
    end
endmodule : ccdb_top_test
